//--- rtl/clkgen_consts.svh
// constants for the clock generator configuration block
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte offsets in the configuration block)
// ----------------------------------------------------------------------
`define CLKGEN_OFS_MAX_MULT     8'h10
`define CLKGEN_OFS_CORE_FREQ    8'h1e
`define CLKGEN_OFS_PLL_POWER    8'h20
`define CLKGEN_OFS_CODEC_CFG    8'h24

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CLKGEN_PLL_POWER_RST    8'h2f
`define CLKGEN_CODEC_CFG_RST    32'he1040005

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CLKGEN_FB_FREQ_LSB      8
`define CLKGEN_PWR_PCI_OFF      5
`define CLKGEN_PWR_ONE_BIT      3
`define CLKGEN_PWR_CODEC_OFF    2
`define CLKGEN_PWR_USB_PLL_OFF  1
`define CLKGEN_PWR_PERIPH_OFF   0
`define CLKGEN_CORE_FREQ_WMASK  16'hcc0f

// ----------------------------------------------------------------------
// strap patterns and multipliers
// ----------------------------------------------------------------------
`define CLKGEN_STRAP_33_X7      4'h0
`define CLKGEN_STRAP_33_X8      4'h4
`define CLKGEN_STRAP_33_X9      4'h8
`define CLKGEN_STRAP_66_X4      4'h6
`define CLKGEN_MULT_MIN         4'h4
`define CLKGEN_MULT_MAX         4'ha

// ----------------------------------------------------------------------
// fast bus frequency codes
// ----------------------------------------------------------------------
`define CLKGEN_FB_33_A          2'h0
`define CLKGEN_FB_RSVD          2'h1
`define CLKGEN_FB_66            2'h2
`define CLKGEN_FB_33_B          2'h3

`endif

//--- rtl/clkgen_pkg.sv
// types for the clock generator configuration block
package clkgen_pkg;
	typedef enum logic [1:0] {
		CLKGEN_REF_FAST33,
		CLKGEN_REF_FAST66
	} clkgen_ref_t;
endpackage : clkgen_pkg

//--- rtl/clkgen_gate.sv
// glitch-free gate for one derived clock enable stream
`timescale 1ns/1ps
`default_nettype none
module clkgen_gate (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// source phase and control
	input  wire logic src_phase,
	input  wire logic stop_req,
	// gated phase
	output var  logic gated_phase
);
	logic run;

	// run changes only while the source phase is low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run <= 1'b0;
		end else if (!src_phase) begin
			run <= !stop_req; // [R23]
		end
	end

	assign gated_phase = src_phase & run;

	chk_gate_low_only: assert property ( // [R23]
		@(posedge core_clk) disable iff (sys_rst)
		$changed(run) |-> !$past(src_phase))
		else $error("gate changed during high phase");
endmodule : clkgen_gate
`default_nettype wire

//--- rtl/clkgen_top.sv
// clock generator configuration: straps, registers and clock phases
// Notes on behaviour
// R1: core multiplier is whole number 4 to 10
// R2: multiplier loaded from straps at reset
// R3: straps also pick multiplier reference clock
// R4: fast bus 33 or 66 by low straps
// R5: strap patterns map to frequency and multiplier
// R6: bits 9:8 mirror the two low straps
// R7: multiplier field bits 3:0 drives core generator
// R8: software writes the multiplier field, not the maximum multiplier
// R9: maximum multiplier captured from straps, read only
// R10: power register resets 2Fh, gates clocks
// R11: bit set stops external PCI clock
// R12: bit set shuts down codec PLL
// R13: bit set disables USB peripheral clock
// R14: software writes reserved one bit as one
// R15: codec config resets E1040005h, holds counters
// R16: codec output is ref times fb over ff*out
// R17: software keeps core control bits 13:12 zero
// R18: USB PLL gives 48 MHz clock
// R19: ACPI multiplier gives 14.32 MHz clock
// R20: PCI PLL 66.67 MHz halved to 33.3
// R21: codec PLL drives 24.576 MHz codec clock
// R22: RTC clock passes straight from 32 kHz
// R23: gates open or close only in low phase
`include "clkgen_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clkgen_top (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// straps
	input  wire logic [3:0]  clock_select_straps,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output var  logic [31:0] reg_rdata,
	// raw clock phases from the analog generators
	input  wire logic        rtc_xtal_phase,
	input  wire logic        usb_pll_phase,
	input  wire logic        acpi_mult_phase,
	input  wire logic        pci_pll_phase,
	input  wire logic        codec_pll_phase,
	// generator control
	output var  logic [3:0]  core_mult,
	output var  logic        core_ref_fast66,
	output var  logic        fast_bus_66,
	output var  logic        usb_pll_off,
	output var  logic        codec_pll_off,
	output var  logic [31:0] codec_pll_cfg,
	// derived clock phases
	output var  logic        rtc_clock_out,
	output var  logic        usb_clock_out,
	output var  logic        periph_clock_out,
	output var  logic        acpi_clock_out,
	output var  logic        pci_clock_out,
	output var  logic        codec_clock_out
);
	// ------------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------------
	logic       strap_taken;
	logic [3:0] max_mult;
	logic [1:0] fast_code;
	logic [3:0] next_max_mult;
	clkgen_pkg::clkgen_ref_t ref_sel;
	clkgen_pkg::clkgen_ref_t next_ref_sel;

	// strap table; unlisted patterns fall back to the slowest setting
	always_comb begin
		next_max_mult = 4'h7; // [R5]
		next_ref_sel  = clkgen_pkg::CLKGEN_REF_FAST33;
		unique case (clock_select_straps)
			`CLKGEN_STRAP_33_X7: next_max_mult = 4'h7; // [R5]
			`CLKGEN_STRAP_33_X8: next_max_mult = 4'h8; // [R5]
			`CLKGEN_STRAP_33_X9: next_max_mult = 4'h9; // [R5]
			`CLKGEN_STRAP_66_X4: begin
				next_max_mult = 4'h4; // [R5]
				next_ref_sel  = clkgen_pkg::CLKGEN_REF_FAST66; // [R3]
			end
			default: next_max_mult = 4'h7;
		endcase
	end

	// straps are caught by the first clock after reset release
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_taken <= 1'b0;
			max_mult    <= 4'h7;
			fast_code   <= 2'h0;
			ref_sel     <= clkgen_pkg::CLKGEN_REF_FAST33;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			max_mult    <= next_max_mult; // [R2] [R9]
			fast_code   <= clock_select_straps[1:0]; // [R4] [R6]
			ref_sel     <= next_ref_sel; // [R3]
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [3:0]  mult_field;
	logic [15:0] core_ctl_hi;
	logic [7:0]  pll_power;
	logic [31:0] codec_cfg;
	logic [3:0]  wr_mult;

	wire sel_max   = reg_addr == `CLKGEN_OFS_MAX_MULT;
	wire sel_core  = reg_addr == `CLKGEN_OFS_CORE_FREQ;
	wire sel_power = reg_addr == `CLKGEN_OFS_PLL_POWER;
	wire sel_codec = reg_addr == `CLKGEN_OFS_CODEC_CFG;

	// only the whole-number range 4..10 may reach the generator
	assign wr_mult = reg_wdata[3:0];
	wire mult_ok = (wr_mult >= `CLKGEN_MULT_MIN) &&
		(wr_mult <= `CLKGEN_MULT_MAX); // [R1]

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mult_field  <= 4'h7;
			core_ctl_hi <= 16'h0000;
			pll_power   <= `CLKGEN_PLL_POWER_RST; // [R10]
			codec_cfg   <= `CLKGEN_CODEC_CFG_RST; // [R15]
		end else begin
			if (!strap_taken) begin
				mult_field <= next_max_mult; // [R2] [R7]
			end else if (reg_wr && sel_core && mult_ok) begin
				mult_field <= wr_mult; // [R7] [R1]
			end
			if (reg_wr && sel_core) begin
				core_ctl_hi <= reg_wdata[15:0] &
					`CLKGEN_CORE_FREQ_WMASK & 16'hfcf0;
			end
			if (reg_wr && sel_power) begin
				pll_power <= reg_wdata[7:0]; // [R10]
			end
			if (reg_wr && sel_codec) begin
				codec_cfg <= reg_wdata; // [R15]
			end
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	wire [31:0] rd_max   = {28'h0, max_mult}; // [R9]
	wire [31:0] rd_core  = {16'h0, core_ctl_hi[15:10], fast_code,
		core_ctl_hi[7:4], mult_field}; // [R6] [R7]
	wire [31:0] rd_power = {24'h0, pll_power};
	wire [31:0] next_rdata = sel_max   ? rd_max :
		sel_core  ? rd_core :
		sel_power ? rd_power :
		sel_codec ? codec_cfg : 32'h0;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// generator control outputs
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_mult       <= 4'h7;
			core_ref_fast66 <= 1'b0;
			fast_bus_66     <= 1'b0;
			usb_pll_off     <= 1'b0;
			codec_pll_off   <= 1'b1;
			codec_pll_cfg   <= `CLKGEN_CODEC_CFG_RST;
		end else begin
			core_mult       <= mult_field; // [R1] [R7]
			core_ref_fast66 <= ref_sel == clkgen_pkg::CLKGEN_REF_FAST66;
			fast_bus_66     <= fast_code == `CLKGEN_FB_66; // [R4]
			usb_pll_off     <= pll_power[`CLKGEN_PWR_USB_PLL_OFF];
			codec_pll_off   <= pll_power[`CLKGEN_PWR_CODEC_OFF]; // [R12]
			codec_pll_cfg   <= codec_cfg; // [R16]
		end
	end

	// ------------------------------------------------------------------
	// derived clocks
	// ------------------------------------------------------------------
	logic pci_half;
	logic acpi_div;
	logic acpi_phase_d;
	logic [1:0] acpi_cnt;

	// 66.67 MHz halved; 57.278 MHz quartered to 14.32 MHz
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pci_half     <= 1'b0;
			acpi_phase_d <= 1'b0;
			acpi_cnt     <= 2'h0;
			acpi_div     <= 1'b0;
		end else begin
			pci_half     <= pci_pll_phase ? !pci_half : pci_half; // [R20]
			acpi_phase_d <= acpi_mult_phase;
			if (acpi_mult_phase && !acpi_phase_d) begin
				acpi_cnt <= acpi_cnt + 2'h1; // [R19]
				acpi_div <= acpi_cnt[1];
			end
		end
	end

	assign rtc_clock_out  = rtc_xtal_phase; // [R22]
	assign acpi_clock_out = acpi_div; // [R19]

	wire [3:0] gate_src  = {pci_half, codec_pll_phase, usb_pll_phase,
		usb_pll_phase};
	wire [3:0] gate_stop = {pll_power[`CLKGEN_PWR_PCI_OFF],
		pll_power[`CLKGEN_PWR_CODEC_OFF],
		pll_power[`CLKGEN_PWR_USB_PLL_OFF] |
		pll_power[`CLKGEN_PWR_PERIPH_OFF],
		pll_power[`CLKGEN_PWR_USB_PLL_OFF] |
		pll_power[`CLKGEN_PWR_PERIPH_OFF]};
	logic [3:0] gate_out;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gate
			clkgen_gate u_gate (
				.core_clk    (core_clk),
				.sys_rst     (sys_rst),
				.src_phase   (gate_src[gi]),
				.stop_req    (gate_stop[gi]), // [R11] [R12] [R13]
				.gated_phase (gate_out[gi])
			);
		end
	endgenerate

	assign pci_clock_out    = gate_out[3]; // [R11] [R20]
	assign codec_clock_out  = gate_out[2]; // [R21] [R12]
	assign usb_clock_out    = gate_out[1]; // [R18] [R13]
	assign periph_clock_out = gate_out[0]; // [R13] [R18]

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_power_write_stop;
		reg_wr && sel_power && reg_wdata[`CLKGEN_PWR_PCI_OFF];
	endsequence

	chk_mult_range: assert property ( // [R1]
		@(posedge core_clk) disable iff (sys_rst)
		strap_taken |-> core_mult >= 4'h4 && core_mult <= 4'ha)
		else $error("core multiplier out of range");

	chk_strap_mult: assert property ( // [R2]
		@(posedge core_clk) disable iff (sys_rst)
		!strap_taken |=> mult_field == max_mult)
		else $error("multiplier not loaded from straps");

	chk_fast_field: assert property ( // [R6]
		@(posedge core_clk) disable iff (sys_rst)
		strap_taken && reg_rd && sel_core |=>
		reg_rdata[9:8] == fast_code)
		else $error("fast bus field mismatch");

	chk_ref_sel: assert property ( // [R3]
		@(posedge core_clk) disable iff (sys_rst)
		strap_taken |=> core_ref_fast66 == (max_mult == 4'h4))
		else $error("reference select mismatch");

	chk_pci_stop: assert property ( // [R11]
		@(posedge core_clk) disable iff (sys_rst)
		s_power_write_stop ##1 (!pci_half [*2]) |=>
		!pci_clock_out)
		else $error("pci clock not stopped");

	chk_codec_off: assert property ( // [R12]
		@(posedge core_clk) disable iff (sys_rst)
		reg_wr && sel_power |-> ##2
		codec_pll_off == $past(reg_wdata[`CLKGEN_PWR_CODEC_OFF], 2))
		else $error("codec pll control lag");

	chk_power_rd: assert property ( // [R10]
		@(posedge core_clk) disable iff (sys_rst)
		reg_wr && sel_power ##1 reg_rd && sel_power && !reg_wr |=>
		reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
		else $error("power register readback");

	chk_codec_cfg: assert property ( // [R15]
		@(posedge core_clk) disable iff (sys_rst)
		reg_wr && sel_codec |-> ##2 codec_pll_cfg == $past(reg_wdata, 2))
		else $error("codec config not applied");

	chk_rtc_pass: assert property ( // [R22]
		@(posedge core_clk) disable iff (sys_rst)
		rtc_clock_out == rtc_xtal_phase)
		else $error("rtc clock not passed through");
endmodule : clkgen_top
`default_nettype wire

//--- testbench/clock_generator_config_tb.sv
// self-checking bench for the clock generator configuration block
`include "clkgen_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_generator_config_tb;
	logic        core_clk = 1'b0;
	logic        sys_rst;
	logic [3:0]  straps;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [4:0]  ph = 5'h00;
	logic [3:0]  core_mult;
	logic        ref66;
	logic        fast_bus_66;
	logic        usb_pll_off;
	logic        codec_pll_off;
	logic [31:0] codec_pll_cfg;
	logic        rtc_out;
	logic        acpi_out;
	logic        acpi_prev = 1'b0;
	logic [3:0]  gclk;
	logic [3:0]  gprev = 4'h0;
	int          gcnt [4] = '{0, 0, 0, 0};
	int          acpi_rises = 0;
	int          num_errors;
	int          num_checks;

	clkgen_top u_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .clock_select_straps(straps),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rtc_xtal_phase(ph[0]), .usb_pll_phase(ph[1]),
		.acpi_mult_phase(ph[2]), .pci_pll_phase(ph[3]),
		.codec_pll_phase(ph[4]), .core_mult(core_mult),
		.core_ref_fast66(ref66), .fast_bus_66(fast_bus_66),
		.usb_pll_off(usb_pll_off), .codec_pll_off(codec_pll_off),
		.codec_pll_cfg(codec_pll_cfg), .rtc_clock_out(rtc_out),
		.usb_clock_out(gclk[1]), .periph_clock_out(gclk[0]),
		.acpi_clock_out(acpi_out), .pci_clock_out(gclk[3]),
		.codec_clock_out(gclk[2])
	);

	always #5 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// raw phases and edge counters
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		ph <= ~ph;
		gprev <= gclk;
		acpi_prev <= acpi_out;
		for (int i = 0; i < 4; i++)
			if (gclk[i] !== gprev[i])
				gcnt[i] <= gcnt[i] + 1;
		if (acpi_out === 1'b1 && acpi_prev === 1'b0)
			acpi_rises <= acpi_rises + 1;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	task automatic do_reset(input logic [3:0] s);
		sys_rst <= 1'b1;
		straps <= s;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask : do_reset

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// write then read in the very next cycle
	task automatic reg_wr_rd(input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= wd;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask : reg_wr_rd

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values();
		logic [31:0] d;
		reg_read(`CLKGEN_OFS_PLL_POWER, d);
		check("power reset", d, 32'h2f);
		reg_read(`CLKGEN_OFS_CODEC_CFG, d);
		check("codec reset", d, 32'he1040005);
		check("codec out", codec_pll_cfg, 32'he1040005);
		reg_read(8'h40, d);
		check("unmapped", d, 32'h0);
		reg_write(`CLKGEN_OFS_CODEC_CFG, 32'he1050007);
		reg_read(`CLKGEN_OFS_CODEC_CFG, d);
		check("codec write", d, 32'he1050007);
		check("codec out wr", codec_pll_cfg, 32'he1050007);
	endtask : reset_values

	task automatic free_clocks();
		int a0;
		repeat (4) begin
			@(negedge core_clk);
			check("rtc pass", 32'(rtc_out), 32'(ph[0]));
		end
		a0 = acpi_rises;
		repeat (64) @(posedge core_clk);
		check("acpi div", 32'((acpi_rises - a0) inside {[7:9]}), 32'h1);
	endtask : free_clocks

	task automatic mult_case(input logic [3:0] v, input logic [3:0] exp);
		logic [31:0] d;
		reg_write(`CLKGEN_OFS_CORE_FREQ, {22'h3, 6'h30, v});
		reg_read(`CLKGEN_OFS_CORE_FREQ, d);
		check("mult field", 32'(d[3:0]), 32'(exp));
		check("fast bus ro", 32'(d[9:8]), 32'h0);
		check("core mult", 32'(core_mult), 32'(exp));
	endtask : mult_case

	task automatic power_case(input logic [7:0] v);
		int          b [4];
		logic [3:0]  run;
		logic [31:0] d;
		run = {~v[5], ~v[2], ~(v[1] | v[0]), ~(v[1] | v[0])};
		reg_wr_rd(`CLKGEN_OFS_PLL_POWER, {24'h0, v}, d);
		check("power wr rd", d, {24'h0, v});
		repeat (6) @(posedge core_clk);
		b = gcnt;
		repeat (16) @(posedge core_clk);
		for (int i = 0; i < 4; i++)
			check("clock run", 32'(gcnt[i] != b[i]), 32'(run[i]));
		check("usb pll off", 32'(usb_pll_off), 32'(v[1]));
		check("codec pll off", 32'(codec_pll_off), 32'(v[2]));
		reg_read(`CLKGEN_OFS_PLL_POWER, d);
		check("power rd", d, {24'h0, v});
	endtask : power_case

	task automatic strap_case(input logic [3:0] s, input logic [3:0] m);
		logic [31:0] d;
		do_reset(s);
		check("core mult", 32'(core_mult), 32'(m));
		check("fast bus 66", 32'(fast_bus_66), 32'(s[1:0] == 2'h2));
		check("ref 66", 32'(ref66), 32'(s == `CLKGEN_STRAP_66_X4));
		reg_read(`CLKGEN_OFS_CORE_FREQ, d);
		check("mult field", 32'(d[3:0]), 32'(m));
		check("fast field", 32'(d[9:8]), 32'(s[1:0]));
		straps <= ~s;
		reg_write(`CLKGEN_OFS_MAX_MULT, 32'hff);
		reg_read(`CLKGEN_OFS_MAX_MULT, d);
		check("max mult", 32'(d[3:0]), 32'(m));
	endtask : strap_case

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		straps = 4'h0;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
		num_errors = 0;
		num_checks = 0;
		do_reset(`CLKGEN_STRAP_33_X7);
		reset_values();
		free_clocks();
		mult_case(4'h3, 4'h7);
		mult_case(4'hb, 4'h7);
		mult_case(4'ha, 4'ha);
		mult_case(4'h4, 4'h4);
		mult_case(4'h7, 4'h7);
		power_case(8'h08);
		power_case(8'h09);
		power_case(8'h0a);
		power_case(8'h0c);
		power_case(8'h28);
		power_case(8'h2f);
		strap_case(`CLKGEN_STRAP_33_X7, 4'h7);
		strap_case(`CLKGEN_STRAP_33_X8, 4'h8);
		strap_case(`CLKGEN_STRAP_33_X9, 4'h9);
		strap_case(`CLKGEN_STRAP_66_X4, 4'h4);
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		end_of_test();
	end
endmodule : clock_generator_config_tb
`default_nettype wire
